// >>> src/rogrb_bank.sv
// offset and gain trim register bank with avalon slave
//
// Operation
// - each colour keeps an 8-bit offset code, reset zero, driving its offset
// - offset broadcast write loads one value into all three offset codes
// - red gain code is red low bit under red upper byte at 0x28
// - green gain code is green low bit under green upper byte at 0x29
// - blue gain code is blue low bit under blue upper byte at 0x2a
// - low-gain broadcast write loads one bit into all three low bits
// - high-gain broadcast write loads one byte into all three upper bytes
// - curve select clear: gain is 416 over 566 minus code
// - curve select set: gain is one plus four times code over 511
`timescale 1ns/1ps
`include "rogrb_defs.svh"

module rogrb_bank
	import rogrb_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int GAIN_FRAC = 12,
	parameter int GAIN_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic [1:0] avs_response,
	output logic avs_waitrequest,
	output rogrb_byte_t red_offset_code,
	output rogrb_byte_t green_offset_code,
	output rogrb_byte_t blue_offset_code,
	output rogrb_code_t red_gain_code,
	output rogrb_code_t green_gain_code,
	output rogrb_code_t blue_gain_code,
	output logic gain_curve_select,
	output logic [GAIN_W-1:0] red_gain,
	output logic [GAIN_W-1:0] green_gain,
	output logic [GAIN_W-1:0] blue_gain
);

	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	if (ADDR_W < 8 || ADDR_W > 32 || GAIN_W > 32) begin : g_chk
		$error("rogrb_bank: unsupported address or gain width");
	end

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	rogrb_bus_state_e state_q;
	rogrb_bus_state_e state_d;
	logic req;
	logic st_ack;
	logic wr_fire;
	logic wr_en;

	assign req = avs_read | avs_write;
	assign st_ack = (state_q == ROGRB_ST_ACK);
	assign avs_waitrequest = req & ~st_ack;
	assign wr_fire = avs_write & st_ack;
	assign wr_en = wr_fire & avs_byteenable[`ROGRB_BYTE_LANE];

	always_comb begin
		state_d = state_q;
		case (state_q)
			ROGRB_ST_IDLE: begin
				if (req) begin
					state_d = ROGRB_ST_ACK;
				end
			end
			ROGRB_ST_ACK: begin
				state_d = ROGRB_ST_IDLE;
			end
			default: begin
				state_d = ROGRB_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ROGRB_ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic [5:0] idx;
	logic upper_zero;
	logic hit_red_off;
	logic hit_grn_off;
	logic hit_blu_off;
	logic hit_all_off;
	logic hit_red_lo;
	logic hit_grn_lo;
	logic hit_blu_lo;
	logic hit_all_lo;
	logic hit_red_hi;
	logic hit_grn_hi;
	logic hit_blu_hi;
	logic hit_all_hi;
	logic hit_ctrl;

	assign idx = avs_address[`ROGRB_IDX_LSB +: 6];
	assign upper_zero = (avs_address >> (`ROGRB_IDX_LSB + 6)) == '0;
	assign hit_red_off = upper_zero & (idx == `ROGRB_IDX_RED_OFF);
	assign hit_grn_off = upper_zero & (idx == `ROGRB_IDX_GRN_OFF);
	assign hit_blu_off = upper_zero & (idx == `ROGRB_IDX_BLU_OFF);
	assign hit_all_off = upper_zero & (idx == `ROGRB_IDX_ALL_OFF);
	assign hit_red_lo = upper_zero & (idx == `ROGRB_IDX_RED_LO);
	assign hit_grn_lo = upper_zero & (idx == `ROGRB_IDX_GRN_LO);
	assign hit_blu_lo = upper_zero & (idx == `ROGRB_IDX_BLU_LO);
	assign hit_all_lo = upper_zero & (idx == `ROGRB_IDX_ALL_LO);
	assign hit_red_hi = upper_zero & (idx == `ROGRB_IDX_RED_HI);
	assign hit_grn_hi = upper_zero & (idx == `ROGRB_IDX_GRN_HI);
	assign hit_blu_hi = upper_zero & (idx == `ROGRB_IDX_BLU_HI);
	assign hit_all_hi = upper_zero & (idx == `ROGRB_IDX_ALL_HI);
	assign hit_ctrl = upper_zero & (idx == `ROGRB_IDX_CTRL);

	// ----------------------------------------
	// write enables
	// ----------------------------------------
	logic we_red_off;
	logic we_grn_off;
	logic we_blu_off;
	logic we_red_lo;
	logic we_grn_lo;
	logic we_blu_lo;
	logic we_red_hi;
	logic we_grn_hi;
	logic we_blu_hi;
	logic we_ctrl;
	rogrb_byte_t wr_byte;
	logic wr_bit;

	assign wr_byte = avs_writedata[7:0];
	assign wr_bit = avs_writedata[`ROGRB_LO_BIT];
	assign we_red_off = wr_en & (hit_red_off | hit_all_off);
	assign we_grn_off = wr_en & (hit_grn_off | hit_all_off);
	assign we_blu_off = wr_en & (hit_blu_off | hit_all_off);
	assign we_red_lo = wr_en & (hit_red_lo | hit_all_lo);
	assign we_grn_lo = wr_en & (hit_grn_lo | hit_all_lo);
	assign we_blu_lo = wr_en & (hit_blu_lo | hit_all_lo);
	assign we_red_hi = wr_en & (hit_red_hi | hit_all_hi);
	assign we_grn_hi = wr_en & (hit_grn_hi | hit_all_hi);
	assign we_blu_hi = wr_en & (hit_blu_hi | hit_all_hi);
	assign we_ctrl = wr_en & hit_ctrl;

	// ----------------------------------------
	// offset code registers
	// ----------------------------------------
	rogrb_byte_t red_off_q;
	rogrb_byte_t grn_off_q;
	rogrb_byte_t blu_off_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			red_off_q <= `ROGRB_OFF_RST;
			grn_off_q <= `ROGRB_OFF_RST;
			blu_off_q <= `ROGRB_OFF_RST;
		end else begin
			if (we_red_off) begin
				red_off_q <= wr_byte;
			end
			if (we_grn_off) begin
				grn_off_q <= wr_byte;
			end
			if (we_blu_off) begin
				blu_off_q <= wr_byte;
			end
		end
	end

	assign red_offset_code = red_off_q;
	assign green_offset_code = grn_off_q;
	assign blue_offset_code = blu_off_q;

	// ----------------------------------------
	// gain low bit registers
	// ----------------------------------------
	logic red_lo_q;
	logic grn_lo_q;
	logic blu_lo_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			red_lo_q <= `ROGRB_LO_RST;
			grn_lo_q <= `ROGRB_LO_RST;
			blu_lo_q <= `ROGRB_LO_RST;
		end else begin
			if (we_red_lo) begin
				red_lo_q <= wr_bit;
			end
			if (we_grn_lo) begin
				grn_lo_q <= wr_bit;
			end
			if (we_blu_lo) begin
				blu_lo_q <= wr_bit;
			end
		end
	end

	// ----------------------------------------
	// gain upper byte registers
	// ----------------------------------------
	rogrb_byte_t red_hi_q;
	rogrb_byte_t grn_hi_q;
	rogrb_byte_t blu_hi_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			red_hi_q <= `ROGRB_HI_RST;
			grn_hi_q <= `ROGRB_HI_RST;
			blu_hi_q <= `ROGRB_HI_RST;
		end else begin
			if (we_red_hi) begin
				red_hi_q <= wr_byte;
			end
			if (we_grn_hi) begin
				grn_hi_q <= wr_byte;
			end
			if (we_blu_hi) begin
				blu_hi_q <= wr_byte;
			end
		end
	end

	// ----------------------------------------
	// curve select control
	// ----------------------------------------
	logic curve_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			curve_q <= `ROGRB_CURVE_RST;
		end else if (we_ctrl) begin
			curve_q <= avs_writedata[`ROGRB_CURVE_BIT];
		end
	end

	assign gain_curve_select = curve_q;

	// ----------------------------------------
	// gain code assembly
	// ----------------------------------------
	// red, green and blue codes
	assign red_gain_code = {red_hi_q, red_lo_q};
	assign green_gain_code = {grn_hi_q, grn_lo_q};
	assign blue_gain_code = {blu_hi_q, blu_lo_q};

	// ----------------------------------------
	// gain curves
	// ----------------------------------------
	rogrb_gain_curve #(
		.GAIN_FRAC(GAIN_FRAC),
		.GAIN_W(GAIN_W)
	) u_curve_red (
		.clk(clk),
		.rst(rst),
		.gain_code(red_gain_code),
		.gain_curve_select(curve_q),
		.gain_q(red_gain)
	);

	rogrb_gain_curve #(
		.GAIN_FRAC(GAIN_FRAC),
		.GAIN_W(GAIN_W)
	) u_curve_grn (
		.clk(clk),
		.rst(rst),
		.gain_code(green_gain_code),
		.gain_curve_select(curve_q),
		.gain_q(green_gain)
	);

	rogrb_gain_curve #(
		.GAIN_FRAC(GAIN_FRAC),
		.GAIN_W(GAIN_W)
	) u_curve_blu (
		.clk(clk),
		.rst(rst),
		.gain_code(blue_gain_code),
		.gain_curve_select(curve_q),
		.gain_q(blue_gain)
	);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	logic [31:0] rd_d;
	logic [1:0] resp_d;
	logic [31:0] rd_q;
	logic [1:0] resp_q;
	logic hit_any;

	assign hit_any = upper_zero & (idx >= `ROGRB_IDX_RED_OFF) & (idx <= `ROGRB_IDX_BLU_GAIN);

	always_comb begin
		rd_d = 32'h00000000;
		resp_d = hit_any ? `ROGRB_RESP_OKAY : `ROGRB_RESP_DECODE;
		if (hit_red_off) begin
			rd_d[7:0] = red_off_q;
		end else if (hit_grn_off) begin
			rd_d[7:0] = grn_off_q;
		end else if (hit_blu_off) begin
			rd_d[7:0] = blu_off_q;
		end else if (hit_red_lo) begin
			rd_d[`ROGRB_LO_BIT] = red_lo_q;
		end else if (hit_grn_lo) begin
			rd_d[`ROGRB_LO_BIT] = grn_lo_q;
		end else if (hit_blu_lo) begin
			rd_d[`ROGRB_LO_BIT] = blu_lo_q;
		end else if (hit_red_hi) begin
			rd_d[7:0] = red_hi_q;
		end else if (hit_grn_hi) begin
			rd_d[7:0] = grn_hi_q;
		end else if (hit_blu_hi) begin
			rd_d[7:0] = blu_hi_q;
		end else if (hit_ctrl) begin
			rd_d[`ROGRB_CURVE_BIT] = curve_q;
		end else if (upper_zero & (idx == `ROGRB_IDX_RED_GAIN)) begin
			rd_d[GAIN_W-1:0] = red_gain;
		end else if (upper_zero & (idx == `ROGRB_IDX_GRN_GAIN)) begin
			rd_d[GAIN_W-1:0] = green_gain;
		end else if (upper_zero & (idx == `ROGRB_IDX_BLU_GAIN)) begin
			rd_d[GAIN_W-1:0] = blue_gain;
		end else begin
			rd_d = 32'h00000000;
		end
	end

	// read data captured as the request is seen, held through the ack cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_q <= 32'h00000000;
			resp_q <= `ROGRB_RESP_OKAY;
		end else if (req & ~st_ack) begin
			rd_q <= avs_read ? rd_d : 32'h00000000;
			resp_q <= resp_d;
		end
	end

	assign avs_readdata = rd_q;
	assign avs_response = resp_q;

endmodule : rogrb_bank

// >>> src/rogrb_defs.svh
// register indices, field positions, reset values and curve constants
`ifndef ROGRB_DEFS_SVH
`define ROGRB_DEFS_SVH

// ----------------------------------------
// register word indices (byte address = 4 x index)
// ----------------------------------------
`define ROGRB_IDX_RED_OFF 6'h20
`define ROGRB_IDX_GRN_OFF 6'h21
`define ROGRB_IDX_BLU_OFF 6'h22
`define ROGRB_IDX_ALL_OFF 6'h23
`define ROGRB_IDX_RED_LO 6'h24
`define ROGRB_IDX_GRN_LO 6'h25
`define ROGRB_IDX_BLU_LO 6'h26
`define ROGRB_IDX_ALL_LO 6'h27
`define ROGRB_IDX_RED_HI 6'h28
`define ROGRB_IDX_GRN_HI 6'h29
`define ROGRB_IDX_BLU_HI 6'h2a
`define ROGRB_IDX_ALL_HI 6'h2b
`define ROGRB_IDX_CTRL 6'h2c
`define ROGRB_IDX_RED_GAIN 6'h2d
`define ROGRB_IDX_GRN_GAIN 6'h2e
`define ROGRB_IDX_BLU_GAIN 6'h2f

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define ROGRB_IDX_LSB 2
`define ROGRB_LO_BIT 0
`define ROGRB_CURVE_BIT 0
`define ROGRB_BYTE_LANE 0
`define ROGRB_OFF_RST 8'h00
`define ROGRB_HI_RST 8'h00
`define ROGRB_LO_RST 1'h0
`define ROGRB_CURVE_RST 1'h0

// ----------------------------------------
// avalon response codes
// ----------------------------------------
`define ROGRB_RESP_OKAY 2'h0
`define ROGRB_RESP_DECODE 2'h3

// ----------------------------------------
// gain curve constants
// ----------------------------------------
`define ROGRB_CURVE0_NUM 24'h0001a0
`define ROGRB_CURVE0_BASE 24'h000236
`define ROGRB_CURVE1_MUL 24'h000004
`define ROGRB_CURVE1_DIV 24'h0001ff
`define ROGRB_ONE 24'h000001

`endif

// >>> src/rogrb_pkg.sv
// shared types of the offset and gain register bank
package rogrb_pkg;

	typedef logic [7:0] rogrb_byte_t;
	typedef logic [8:0] rogrb_code_t;
	typedef logic [23:0] rogrb_wide_t;

	typedef enum logic [1:0] {
		ROGRB_ST_IDLE = 2'b01,
		ROGRB_ST_ACK = 2'b10
	} rogrb_bus_state_e;

endpackage : rogrb_pkg

// >>> src/rogrb_gain_curve.sv
// one channel gain code to fixed point voltage gain
`timescale 1ns/1ps
`include "rogrb_defs.svh"

module rogrb_gain_curve
	import rogrb_pkg::*;
#(
	parameter int GAIN_FRAC = 12,
	parameter int GAIN_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire rogrb_code_t gain_code,
	input wire logic gain_curve_select,
	output logic [GAIN_W-1:0] gain_q
);

	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	if (GAIN_FRAC < 1 || GAIN_FRAC > 13 || GAIN_W < GAIN_FRAC + 4 || GAIN_W > 24) begin : g_chk
		$error("rogrb_gain_curve: unsupported gain format");
	end

	function automatic rogrb_wide_t rogrb_div(input rogrb_wide_t num, input rogrb_wide_t den);
		rogrb_div = num / den;
	endfunction : rogrb_div

	// ----------------------------------------
	// curve arithmetic
	// ----------------------------------------
	rogrb_wide_t code_w;
	rogrb_wide_t den0;
	rogrb_wide_t gain0;
	rogrb_wide_t gain1;
	rogrb_wide_t gain_d;

	assign code_w = {15'h0000, gain_code};
	assign den0 = `ROGRB_CURVE0_BASE - code_w;
	assign gain0 = rogrb_div(`ROGRB_CURVE0_NUM << GAIN_FRAC, den0);
	assign gain1 = (`ROGRB_ONE << GAIN_FRAC)
		+ rogrb_div((code_w * `ROGRB_CURVE1_MUL) << GAIN_FRAC, `ROGRB_CURVE1_DIV);
	assign gain_d = gain_curve_select ? gain1 : gain0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gain_q <= '0;
		end else begin
			gain_q <= gain_d[GAIN_W-1:0];
		end
	end

endmodule : rogrb_gain_curve

// >>> verif/rogrb_bank_properties.sv
// concurrent checks of the offset and gain register bank
`timescale 1ns/1ps
module rogrb_bank_properties
	import rogrb_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic [1:0] avs_response,
	input wire logic avs_waitrequest,
	input wire rogrb_byte_t red_offset_code,
	input wire rogrb_byte_t green_offset_code,
	input wire rogrb_byte_t blue_offset_code,
	input wire rogrb_code_t red_gain_code,
	input wire rogrb_code_t green_gain_code,
	input wire rogrb_code_t blue_gain_code
);
	// ----------------------------------------
	// completed transfers
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire logic wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
	wire logic rd_done = avs_read && !avs_waitrequest;
	wire logic [7:0] wd = avs_writedata[7:0];
	a_red_offset_load: assert property (
		wr_done && avs_address == 8'h80 |=> red_offset_code == $past(wd) && $stable(green_offset_code))
		else $error("red offset write not applied");
	a_offset_bcast_all: assert property (
		wr_done && avs_address == 8'h8c |=> red_offset_code == $past(wd)
		&& green_offset_code == $past(wd) && blue_offset_code == $past(wd))
		else $error("offset broadcast missed a channel");
	a_red_upper_load: assert property (
		wr_done && avs_address == 8'ha0 |=> red_gain_code[8:1] == $past(wd) && $stable(red_gain_code[0]))
		else $error("red upper gain bits wrong");
	a_red_low_load: assert property (
		wr_done && avs_address == 8'h90 |=> red_gain_code == {$past(red_gain_code[8:1]), $past(wd[0])})
		else $error("red low gain bit wrong");
	a_green_upper_load: assert property (
		wr_done && avs_address == 8'ha4 |=> green_gain_code[8:1] == $past(wd))
		else $error("green upper gain bits wrong");
	a_blue_upper_load: assert property (
		wr_done && avs_address == 8'ha8 |=> blue_gain_code[8:1] == $past(wd))
		else $error("blue upper gain bits wrong");
	a_low_bcast_all: assert property (
		wr_done && avs_address == 8'h9c |=> red_gain_code[0] == $past(wd[0])
		&& green_gain_code[0] == $past(wd[0]) && blue_gain_code[0] == $past(wd[0]))
		else $error("low gain broadcast missed a channel");
	a_high_bcast_all: assert property (
		wr_done && avs_address == 8'hac |=> red_gain_code[8:1] == $past(wd)
		&& green_gain_code[8:1] == $past(wd) && blue_gain_code[8:1] == $past(wd))
		else $error("high gain broadcast missed a channel");
	a_bcast_read_zero: assert property (
		rd_done && (avs_address == 8'h8c || avs_address == 8'h9c || avs_address == 8'hac)
		|-> avs_readdata == 32'h0 && avs_response == 2'h0)
		else $error("broadcast read not zero");
endmodule : rogrb_bank_properties

// >>> verif/rogrb_bank_tb.sv
// self-checking bench of the offset and gain register bank
`timescale 1ns/1ps
module rogrb_bank_tb import rogrb_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic [1:0] avs_response;
	logic avs_waitrequest;
	rogrb_byte_t red_offset_code, green_offset_code, blue_offset_code;
	rogrb_code_t red_gain_code, green_gain_code, blue_gain_code;
	logic gain_curve_select;
	logic [15:0] red_gain, green_gain, blue_gain;
	logic [31:0] rd;
	logic [1:0] rs;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	rogrb_bank dut_u (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_response(avs_response),
		.avs_waitrequest(avs_waitrequest), .red_offset_code(red_offset_code),
		.green_offset_code(green_offset_code), .blue_offset_code(blue_offset_code),
		.red_gain_code(red_gain_code), .green_gain_code(green_gain_code),
		.blue_gain_code(blue_gain_code), .gain_curve_select(gain_curve_select),
		.red_gain(red_gain), .green_gain(green_gain), .blue_gain(blue_gain));
	// ----------------------------------------
	// clock and timeout
	// ----------------------------------------
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			complete_run();
		end
	end
	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run
	task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp_val
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		avs_byteenable <= be;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		rs = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h0, d}, 4'h1);
	endtask : wr
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		xfer(1'b0, a, 32'h0, 4'h1);
		cmp_val(name, exp, rd);
		cmp_val({name, " response"}, {30'h0, er}, {30'h0, rs});
	endtask : rd_chk
	function automatic logic [15:0] gexp(input logic sel, input int code);
		return sel ? 16'(4096 + code * 16384 / 511) : 16'(1703936 / (566 - code));
	endfunction : gexp
	task automatic chk_off(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
		repeat (2) @(negedge clk);
		cmp_val("red offset", {24'h0, r}, {24'h0, red_offset_code});
		cmp_val("green offset", {24'h0, g}, {24'h0, green_offset_code});
		cmp_val("blue offset", {24'h0, b}, {24'h0, blue_offset_code});
	endtask : chk_off
	task automatic chk_ch(input logic [8:0] r, input logic [8:0] g, input logic [8:0] b,
		input logic sel);
		repeat (2) @(negedge clk);
		cmp_val("curve select", {31'h0, sel}, {31'h0, gain_curve_select});
		cmp_val("red code", {23'h0, r}, {23'h0, red_gain_code});
		cmp_val("green code", {23'h0, g}, {23'h0, green_gain_code});
		cmp_val("blue code", {23'h0, b}, {23'h0, blue_gain_code});
		cmp_val("red gain", {16'h0, gexp(sel, r)}, {16'h0, red_gain});
		cmp_val("green gain", {16'h0, gexp(sel, g)}, {16'h0, green_gain});
		cmp_val("blue gain", {16'h0, gexp(sel, b)}, {16'h0, blue_gain});
	endtask : chk_ch
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		chk_off(8'h00, 8'h00, 8'h00);
		chk_ch(9'h000, 9'h000, 9'h000, 1'b0);
		for (int a = 8'h80; a <= 8'hb0; a += 4) begin
			rd_chk("reset value", 8'(a), 32'h0, 2'h0);
		end
		rd_chk("reset gain", 8'hb4, 32'h0bc2, 2'h0);
		rd_chk("unmapped", 8'h00, 32'h0, 2'h3);
		wr(8'h80, 8'h11);
		wr(8'h84, 8'h22);
		wr(8'h88, 8'h33);
		xfer(1'b1, 8'h80, 32'hee, 4'h0);
		chk_off(8'h11, 8'h22, 8'h33);
		rd_chk("green offset", 8'h84, 32'h22, 2'h0);
		wr(8'h8c, 8'ha5);
		chk_off(8'ha5, 8'ha5, 8'ha5);
		rd_chk("offset broadcast", 8'h8c, 32'h0, 2'h0);
		wr(8'ha0, 8'h80);
		wr(8'h90, 8'h01);
		wr(8'ha4, 8'h7f);
		wr(8'h94, 8'h00);
		wr(8'ha8, 8'hff);
		wr(8'h98, 8'h01);
		chk_ch(9'h101, 9'h0fe, 9'h1ff, 1'b0);
		rd_chk("blue upper", 8'ha8, 32'hff, 2'h0);
		wr(8'h9c, 8'h00);
		chk_ch(9'h100, 9'h0fe, 9'h1fe, 1'b0);
		wr(8'hac, 8'h3c);
		chk_ch(9'h078, 9'h078, 9'h078, 1'b0);
		rd_chk("red gain", 8'hb4, 32'h0eec, 2'h0);
		rd_chk("low broadcast", 8'h9c, 32'h0, 2'h0);
		rd_chk("high broadcast", 8'hac, 32'h0, 2'h0);
		wr(8'hb0, 8'h01);
		chk_ch(9'h078, 9'h078, 9'h078, 1'b1);
		rd_chk("red gain", 8'hb4, 32'h1f07, 2'h0);
		wr(8'h9c, 8'h01);
		wr(8'hac, 8'hff);
		chk_ch(9'h1ff, 9'h1ff, 9'h1ff, 1'b1);
		wr(8'hb0, 8'h00);
		chk_ch(9'h1ff, 9'h1ff, 9'h1ff, 1'b0);
		wr(8'hb8, 8'h00);
		rd_chk("green gain", 8'hb8, 32'h7904, 2'h0);
		complete_run();
	end
endmodule : rogrb_bank_tb
bind rogrb_bank rogrb_bank_properties #(.ADDR_W(ADDR_W)) prop_u (.clk(clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_response(avs_response),
	.avs_waitrequest(avs_waitrequest), .red_offset_code(red_offset_code),
	.green_offset_code(green_offset_code), .blue_offset_code(blue_offset_code),
	.red_gain_code(red_gain_code), .green_gain_code(green_gain_code),
	.blue_gain_code(blue_gain_code));
